/* File: hdl/act_seq_pkg.sv */
// Constants for the card-side single-wire activation sequencer.
// Assumes a 40 MHz system clock; frame coding lives outside this block.
//
// Functional notes
// - Rising line starts card interface activation
// - Card resumes link, sends first sync
// - Unanswered resume: card gives up, stays silent
// - Repeat request resends sync, else ready
// - Corrupted frame: card stays silent
// - Restart from deactivated omits info field
// - Other interfaces and this link isolated
// - Give up resume after 100 ms
// - Reply resume within 2000 us
// - Deactivated restart: sync within 500 us
package act_seq_pkg;
  localparam int unsigned ClkPeriodPs    = 25000;
  localparam int unsigned GiveUpMs       = 100;
  localparam int unsigned ReplyMaxUs     = 2000;
  localparam int unsigned DeactSyncMaxUs = 500;
  // Longest times round down; reply sent well inside the window
  localparam int unsigned GiveUpCycles   =
    (GiveUpMs * 1000 * 1000) / (ClkPeriodPs / 1000);
  localparam int unsigned ReplyCycles    =
    (ReplyMaxUs * 1000) / (ClkPeriodPs / 1000);
  localparam int unsigned DeactCycles    =
    (DeactSyncMaxUs * 1000) / (ClkPeriodPs / 1000);
  localparam int unsigned CntW           = 23;

  typedef enum logic [1:0] {
    FrmSync  = 2'h1,
    FrmReady = 2'h2
  } frame_kind_t;

  typedef enum logic [5:0] {
    StOff     = 6'h01,
    StWaitSus = 6'h02,
    StResume  = 6'h04,
    StSend    = 6'h08,
    StListen  = 6'h10,
    StMute    = 6'h20
  } act_state_t;
endpackage

/* File: hdl/act_sequencer.sv */
// Card-side activation sequencer for the single-wire link.
// Assumes line level and link states come from the physical layer, and
// frame coding and checking are done by a neighbouring framer.
`timescale 1ns/1ps
`default_nettype none
module act_sequencer
  import act_seq_pkg::*;
#(
  parameter int unsigned GiveUpCyc = act_seq_pkg::GiveUpCycles
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // Line state from the physical layer (asynchronous)
  input  wire logic                     lineLevel,
  input  wire logic                     linkSuspended,
  input  wire logic                     linkActivated,
  // Restart from deactivated state
  input  wire logic                     fromDeactivated,
  // Received power mode frame, same clock
  input  wire logic                     rxFrameValid,
  input  wire logic                     rxFrameGood,
  input  wire logic                     rxRepeatRequest,
  input  wire logic                     rxFullPower,
  // Transmit request towards the framer
  output logic                          resumeReq,
  output logic                          txFrameValid,
  output act_seq_pkg::frame_kind_t      txFrameKind,
  output logic                          txInfoOmit,
  input  wire logic                     txFrameDone,
  // Status
  output logic                          linkActive,
  output logic                          activationFailed,
  output logic                          fullPower
);
  import act_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic       lineLast_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      syncA_q    <= 3'h0;
      syncB_q    <= 3'h0;
      lineLast_q <= 1'b0;
    end else begin
      syncA_q    <= {lineLevel, linkSuspended, linkActivated};
      syncB_q    <= syncA_q;
      lineLast_q <= syncB_q[2];
    end
  end
  logic lineHigh;
  logic lineRise;
  logic susp;
  logic actv;
  assign lineHigh = syncB_q[2];
  assign lineRise = syncB_q[2] & ~lineLast_q;
  assign susp     = syncB_q[1];
  assign actv     = syncB_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Sequencer. Uses only its own reset: no other interface reset
  // reaches it, and it drives nothing of theirs.
  act_state_t        state_q;
  logic [CntW-1:0]   timer_q;
  frame_kind_t       kind_q;
  logic              omit_q;
  logic              timeUp;
  assign timeUp = (timer_q == '0);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q          <= StOff;
      timer_q          <= '0;
      kind_q           <= FrmSync;
      omit_q           <= 1'b0;
      resumeReq        <= 1'b0;
      txFrameValid     <= 1'b0;
      linkActive       <= 1'b0;
      activationFailed <= 1'b0;
      fullPower        <= 1'b0;
    end else if (!lineHigh) begin
      // Line dropped: deactivated, state and requests idle; activationFailed and fullPower hold
      state_q      <= StOff;
      resumeReq    <= 1'b0;
      txFrameValid <= 1'b0;
      linkActive   <= 1'b0;
    end else begin
      if (!timeUp) begin
        timer_q <= timer_q - 1'b1;
      end
      unique case (state_q)
        StOff: begin
          if (lineRise) begin
            state_q          <= StWaitSus;
            omit_q           <= fromDeactivated;
            activationFailed <= 1'b0;
          end
        end
        StWaitSus: begin
          if (susp) begin
            state_q   <= StResume;
            resumeReq <= 1'b1;
            kind_q    <= FrmSync;
            timer_q   <= CntW'(GiveUpCyc);
          end
        end
        StResume: begin
          if (actv) begin
            state_q      <= StSend;
            resumeReq    <= 1'b0;
            txFrameValid <= 1'b1;
          end else if (timeUp) begin
            state_q          <= StMute;
            resumeReq        <= 1'b0;
            activationFailed <= 1'b1;
          end
        end
        StSend: begin
          if (txFrameDone) begin
            txFrameValid <= 1'b0;
            state_q      <= StListen;
            if (kind_q == FrmReady) begin
              linkActive <= 1'b1;
            end
          end
        end
        StListen: begin
          // Corrupted frames are dropped without a reply
          if (rxFrameValid && rxFrameGood) begin
            fullPower    <= rxFullPower;
            kind_q       <= rxRepeatRequest ? FrmSync : FrmReady;
            linkActive   <= 1'b0;
            txFrameValid <= 1'b1;
            state_q      <= StSend;
          end
        end
        StMute: begin
          // Silent until the line is deactivated
          state_q <= StMute;
        end
        default: begin
          state_q <= StOff;
        end
      endcase
    end
  end

  assign txFrameKind = kind_q;
  assign txInfoOmit  = omit_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks. All run on the system clock and sleep through reset; line
  // low is excluded where the forced idle would mask the behaviour.
  give_up_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StResume && timeUp && !actv && lineHigh
    |=> state_q == StMute && activationFailed)
    else $error("resume not abandoned");
  mute_silent_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StMute |-> !txFrameValid && !resumeReq)
    else $error("muted card transmits");
  bad_silent_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StListen && rxFrameValid && !rxFrameGood && lineHigh
    |=> state_q == StListen && !txFrameValid)
    else $error("reply to corrupted frame");
  repeat_sync_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StListen && rxFrameValid && rxFrameGood && lineHigh
    |=> txFrameValid && kind_q == ($past(rxRepeatRequest) ? FrmSync
                                                       : FrmReady))
    else $error("wrong reply kind");
  resume_on_susp_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StWaitSus && susp && lineHigh |=> resumeReq)
    else $error("no resume");
  line_low_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !lineHigh |=> state_q == StOff && !txFrameValid)
    else $error("active while line low");
  omit_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StOff && lineRise |=> txInfoOmit == $past(fromDeactivated))
    else $error("info omit not captured");
  timer_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StResume && !actv && lineHigh ##1 state_q == StResume
    |-> timer_q < GiveUpCyc)
    else $error("timer not running");
  rise_start_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StOff && lineRise |=> state_q == StWaitSus)
    else $error("line rise ignored");
  hold_valid_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    txFrameValid && !txFrameDone && lineHigh |=> txFrameValid)
    else $error("frame request dropped early");
  ready_active_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == StSend && kind_q == FrmReady && txFrameDone && lineHigh
    |=> linkActive)
    else $error("ready frame sent but link not active");
  fail_sticky_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    activationFailed && !(state_q == StOff && lineRise) |=> activationFailed)
    else $error("failure flag lost");

  cv_ready_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    state_q == StSend && kind_q == FrmReady && txFrameDone);
  cv_mute_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    state_q == StMute);
  cv_repeat_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    state_q == StListen && rxFrameValid && rxFrameGood && rxRepeatRequest);
  cv_corrupt_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    state_q == StListen && rxFrameValid && !rxFrameGood);
  cv_restart_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    state_q == StOff && lineRise && fromDeactivated);
endmodule
`default_nettype wire

/* File: verification/front_end_model.sv */
// Behavioural front-end master facing the card-side sequencer.
// Assumes the bench drives the line and frames; this model suspends the
// link, answers resume only when told to, and acts as the framer.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  // Clock
  input  wire logic sys_clk,
  // From card side
  input  wire logic lineLevel,
  input  wire logic resumeReq,
  input  wire logic txFrameValid,
  // Scenario control
  input  wire logic answerResume,
  // To card side
  output logic      linkSuspended,
  output logic      linkActivated,
  output logic      txFrameDone
);
  logic [2:0] doneCnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Link state: suspended once the line is up, all cleared when it drops
  always_ff @(posedge sys_clk) begin
    linkSuspended <= lineLevel;
    if (!lineLevel) begin
      linkActivated <= 1'b0;
    end else if (resumeReq && answerResume) begin
      linkActivated <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Framer: slow enough that the card must hold its request
  always_ff @(posedge sys_clk) begin
    txFrameDone <= 1'b0;
    if (!txFrameValid) begin
      doneCnt_q <= 3'h0;
    end else if (doneCnt_q != 3'h4) begin
      doneCnt_q <= doneCnt_q + 3'h1;
    end
    if (txFrameValid && doneCnt_q == 3'h3) begin
      txFrameDone <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the card-side activation sequencer.
// Assumes the front-end model answers resume when told to and completes frames.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  err_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
  import act_seq_pkg::*;
  localparam int unsigned GiveUp = 50;
  logic clk, resetn, lineLevel, linkSuspended, linkActivated;
  logic fromDeactivated, rxFrameValid, rxFrameGood, rxRepeatRequest;
  logic rxFullPower, resumeReq, txFrameValid, txInfoOmit, txFrameDone;
  logic linkActive, activationFailed, fullPower, answerResume;
  frame_kind_t txFrameKind;
  int err_count = 0;
  int compares = 0;

  act_sequencer #(.GiveUpCyc(GiveUp)) DUT (.sys_clk(clk), .resetn(resetn),
    .lineLevel(lineLevel), .linkSuspended(linkSuspended),
    .linkActivated(linkActivated), .fromDeactivated(fromDeactivated),
    .rxFrameValid(rxFrameValid), .rxFrameGood(rxFrameGood),
    .rxRepeatRequest(rxRepeatRequest), .rxFullPower(rxFullPower),
    .resumeReq(resumeReq), .txFrameValid(txFrameValid),
    .txFrameKind(txFrameKind), .txInfoOmit(txInfoOmit),
    .txFrameDone(txFrameDone), .linkActive(linkActive),
    .activationFailed(activationFailed), .fullPower(fullPower));
  front_end_model partner (.sys_clk(clk), .lineLevel(lineLevel),
    .resumeReq(resumeReq), .txFrameValid(txFrameValid),
    .answerResume(answerResume), .linkSuspended(linkSuspended),
    .linkActivated(linkActivated), .txFrameDone(txFrameDone));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_until(ref logic s, input logic v, input string nm);
    for (int i = 0; i < 300 && s !== v; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(nm, v, s)
  endtask

  task automatic start(input logic deact);
    @(posedge clk) lineLevel <= 1'b0;
    repeat (4) @(posedge clk);
    lineLevel <= 1'b1;
    fromDeactivated <= deact;
    wait_until(resumeReq, 1'b1, "resumeReq");
  endtask

  task automatic pm(input logic good, input logic fr, input logic full);
    @(posedge clk) rxFrameValid <= 1'b1;
    rxFrameGood <= good;
    rxRepeatRequest <= fr;
    rxFullPower <= full;
    @(posedge clk) rxFrameValid <= 1'b0;
    #1;
  endtask

  task automatic tx_frame(input frame_kind_t kind, input logic omit);
    wait_until(txFrameValid, 1'b1, "txFrameValid");
    `CHK("txFrameKind", kind, txFrameKind)
    `CHK("txInfoOmit", omit, txInfoOmit)
    wait_until(txFrameValid, 1'b0, "txFrameValid low");
  endtask

  task automatic silent(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      `CHK("silent", 1'b0, txFrameValid)
    end
  endtask

  task automatic t_basic();
    answerResume <= 1'b1;
    start(1'b0);
    tx_frame(FrmSync, 1'b0);
    pm(1'b1, 1'b0, 1'b1);
    tx_frame(FrmReady, 1'b0);
    wait_until(linkActive, 1'b1, "linkActive");
    `CHK("fullPower", 1'b1, fullPower)
  endtask

  task automatic t_repeat();
    start(1'b0);
    tx_frame(FrmSync, 1'b0);
    pm(1'b0, 1'b0, 1'b1);
    silent(10);
    pm(1'b1, 1'b1, 1'b0);
    tx_frame(FrmSync, 1'b0);
    pm(1'b1, 1'b0, 1'b0);
    tx_frame(FrmReady, 1'b0);
    wait_until(linkActive, 1'b1, "linkActive");
    `CHK("fullPower", 1'b0, fullPower)
  endtask

  task automatic t_deact();
    start(1'b1);
    tx_frame(FrmSync, 1'b1);
    pm(1'b1, 1'b0, 1'b1);
    tx_frame(FrmReady, 1'b1);
  endtask

  task automatic t_giveup();
    int held;
    held = 0;
    @(posedge clk) answerResume <= 1'b0;
    start(1'b0);
    while (resumeReq === 1'b1 && held < 200) begin
      @(posedge clk);
      #1;
      held++;
    end
    `CHK("giveUpTime", 1'b1, held >= GiveUp - 3 && held <= GiveUp + 3)
    `CHK("activationFailed", 1'b1, activationFailed)
    @(posedge clk) answerResume <= 1'b1;
    pm(1'b1, 1'b0, 1'b1);
    silent(20);
  endtask

  initial begin
    resetn = 1'b0;
    lineLevel = 1'b0;
    fromDeactivated = 1'b0;
    rxFrameValid = 1'b0;
    rxFrameGood = 1'b0;
    rxRepeatRequest = 1'b0;
    rxFullPower = 1'b0;
    answerResume = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_basic();
    t_repeat();
    t_deact();
    t_giveup();
    tally_and_finish();
  end

  // Hang guard, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[ERR] timeout exp done got hang");
    tally_and_finish();
  end
endmodule
`default_nettype wire
